// ==== hdl/wdr_defs.svh ====
/*
  Constants of the windowed watchdog: register offsets, field positions,
  key bytes, reset values and timing figures.
  Assumes it is included by bare name from the watchdog design files.
*/
`ifndef WDR_DEFS_SVH
`define WDR_DEFS_SVH

`define WDR_OFF_CTRL      8'h00
`define WDR_OFF_SVC       8'h04
`define WDR_OFF_STAT      8'h08
`define WDR_OFF_CFG       8'h0C

`define WDR_KEY_FIRST     8'h55
`define WDR_KEY_SECOND    8'hAA

`define WDR_RATE_OFF      3'h0
`define WDR_CTRL_MASK_BIT 8
`define WDR_CTRL_RESET    8'h00
`define WDR_CFG_RESET     3'h0

`define WDR_EXP_BASE      14
`define WDR_EXP_STEP      2
`define WDR_RESUME_TICKS  2
`define WDR_HOLD_W        3
`define WDR_EXP_W         5

`endif

// ==== hdl/wdr_pkg.sv ====
/*
  Types of the windowed watchdog: control and configuration layouts and
  the key sequence states.
  Assumes wdr_defs.svh supplies the numeric constants.
*/
package wdr_pkg;

  typedef struct packed {
    logic       window;
    logic       stop_autonomous_clock_disable;
    logic       sel_high;
    logic       sel_low;
    logic       rsvd;
    logic [2:0] rate;
  } wdr_ctrl_t;

  typedef struct packed {
    logic crystal_oscillator_enable;
    logic pseudo_stop_watchdog_clock_enable;
    logic pseudo_stop_enable;
  } wdr_cfg_t;

  typedef enum logic [1:0] {
    WDR_KEY_IDLE  = 2'h1,
    WDR_KEY_ARMED = 2'h2
  } wdr_key_t;

endpackage

// ==== hdl/wdr_cnt.sv ====
/*
  Time-out counter of the watchdog with end-of-period and window flags.
  Assumes tick_i is a one-cycle pulse per watchdog clock edge and that
  exp_i stays below CNT_W.
*/
`timescale 1ns/1ps
`include "wdr_defs.svh"

module wdr_cnt #(
  parameter int unsigned CNT_W = 27
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clear_i,
  input  wire logic                  tick_i,
  input  wire logic [`WDR_EXP_W-1:0] exp_i,
  output logic      [CNT_W-1:0]      count_o,
  output logic                       expire_o,
  output logic                       window_o
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] last_w;
  logic [CNT_W-1:0] win_w;

  assign last_w   = CNT_W'((64'h1 << exp_i) - 64'h1);
  // Last quarter starts at three quarters of the period
  assign win_w    = last_w - (last_w >> 2);
  assign expire_o = tick_i && (count_q == last_w);
  assign window_o = (count_q >= win_w);
  assign count_o  = count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_q <= '0;
    end else if (tick_i) begin
      count_q <= expire_o ? '0 : count_q + CNT_W'(1);
    end
  end

endmodule

// ==== hdl/wdr_top.sv ====
/*
  Windowed watchdog with a classic Wishbone register slave, three
  selectable watchdog clock sources, stop-mode run or freeze and, in
  normal mode, preload from nonvolatile memory and a write-once control register.
  Assumes the system reset drives rst_i after wdt_reset_o rises, the
  watchdog clocks run below a quarter of clk_i, and stop, mode and
  preload inputs come from logic on clk_i.
*/
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "wdr_defs.svh"

module wdr_top #(
  parameter int unsigned CNT_W        = 27,
  parameter int unsigned EXP_BASE     = `WDR_EXP_BASE,
  parameter int unsigned RESUME_TICKS = `WDR_RESUME_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic        aclk_i,
  input  wire logic        irc_clk_i,
  input  wire logic        osc_clk_i,
  input  wire logic        osc_up_i,
  input  wire logic        stop_mode_i,
  input  wire logic        normal_mode_i,
  input  wire logic        nvm_valid_i,
  input  wire logic [2:0]  nvm_rate_i,
  input  wire logic        nvm_window_i,
  output logic             wdt_reset_o
);

  localparam int unsigned NSYNC = 4;
  localparam logic [`WDR_HOLD_W-1:0] RESUME_CNT =
    `WDR_HOLD_W'(RESUME_TICKS);
  logic [NSYNC-1:0]          async_w, sync1_q, sync2_q;
  logic [2:0]                prev_q, edge_w;
  logic [31:0]               dat_q;
  logic [7:0]                key_w;
  logic [`WDR_HOLD_W-1:0]    holdoff_q;
  logic [CNT_W-1:0]          count_w;
  logic [`WDR_EXP_W-1:0]     exp_w;
  wdr_pkg::wdr_ctrl_t        ctrl_q, new_w;
  wdr_pkg::wdr_cfg_t         cfg_q;
  wdr_pkg::wdr_key_t         key_q;
  logic                      osc_up_w, first_q, ack_q, once_q, preload_on_q;
  logic                      req_w, wr_w, ctrl_wr_w, svc_wr_w, cfg_wr_w;
  logic                      mask_w, locked_w, enabled_w, src_tick_w;
  logic                      stop_run_w, stop_prev_q, run_w, bad_key_w;
  logic                      early_w, serviced_w, reset_q, expire_w, in_win_w;

  // Period exponent of a rate code; code zero is off and never counts
  function automatic logic [`WDR_EXP_W-1:0] rate_exp(
    input logic [2:0] rate
  );
    rate_exp = `WDR_EXP_W'(EXP_BASE +
      `WDR_EXP_STEP * (int'(rate) - 1));
  endfunction

  // True when the byte is the key expected in the given state
  function automatic logic key_ok(
    input wdr_pkg::wdr_key_t st,
    input logic [7:0]        d
  );
    key_ok = ((st == wdr_pkg::WDR_KEY_IDLE) && (d == `WDR_KEY_FIRST)) ||
             ((st == wdr_pkg::WDR_KEY_ARMED) && (d == `WDR_KEY_SECOND));
  endfunction

  // Pin-level clocks and oscillator status cross through two flops
  assign async_w = {osc_up_i, osc_clk_i, irc_clk_i, aclk_i};
  generate
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_q[g] <= 1'h0;
          sync2_q[g] <= 1'h0;
        end else begin
          sync1_q[g] <= async_w[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= sync2_q[2:0];
    end
  end

  assign edge_w   = sync2_q[2:0] & ~prev_q;
  assign osc_up_w = sync2_q[3];
  // One cycle after release belongs to the preload; the bus waits for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_q <= 1'h1;
    end else begin
      first_q <= 1'h0;
    end
  end

  assign req_w     = wb_cyc_i && wb_stb_i && !ack_q && !first_q;
  assign wr_w      = req_w && wb_we_i && wb_sel_i[0];
  assign ctrl_wr_w = wr_w && (wb_adr_i == `WDR_OFF_CTRL);
  assign svc_wr_w  = wr_w && (wb_adr_i == `WDR_OFF_SVC);
  assign cfg_wr_w  = wr_w && (wb_adr_i == `WDR_OFF_CFG);
  assign mask_w    = wb_dat_i[`WDR_CTRL_MASK_BIT];
  assign new_w     = wdr_pkg::wdr_ctrl_t'(wb_dat_i[7:0]);
  assign key_w     = wb_dat_i[7:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= req_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (req_w && !wb_we_i) begin
      unique case (wb_adr_i)
        `WDR_OFF_CTRL: dat_q <= 32'(ctrl_q);
        `WDR_OFF_SVC:  dat_q <= 32'(key_q == wdr_pkg::WDR_KEY_ARMED);
        `WDR_OFF_STAT: dat_q <= 32'({stop_mode_i && !stop_run_w,
                                     in_win_w && enabled_w, enabled_w,
                                     key_q == wdr_pkg::WDR_KEY_ARMED,
                                     once_q});
        `WDR_OFF_CFG:  dat_q <= 32'(cfg_q);
        default:       dat_q <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  // Control register: preload, then in normal mode at most one unmasked update
  assign locked_w = normal_mode_i && once_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `WDR_CTRL_RESET;
    end else if (first_q) begin
      if (normal_mode_i && nvm_valid_i) begin
        ctrl_q.rate   <= nvm_rate_i;
        ctrl_q.window <= nvm_window_i;
      end
    end else if (ctrl_wr_w && !locked_w) begin
      ctrl_q.sel_low  <= new_w.sel_low;
      ctrl_q.sel_high <= new_w.sel_high;
      ctrl_q.stop_autonomous_clock_disable     <= new_w.stop_autonomous_clock_disable;
      if (!mask_w) begin
        if (!(preload_on_q && (new_w.rate == `WDR_RATE_OFF))) begin
          ctrl_q.rate <= new_w.rate;
        end
        ctrl_q.window <= new_w.window;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      once_q <= 1'h0;
    end else if (ctrl_wr_w && normal_mode_i && !mask_w) begin
      once_q <= 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_on_q <= 1'h0;
    end else if (first_q) begin
      preload_on_q <= normal_mode_i && nvm_valid_i &&
                      (nvm_rate_i != `WDR_RATE_OFF);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `WDR_CFG_RESET;
    end else if (cfg_wr_w) begin
      cfg_q <= wdr_pkg::wdr_cfg_t'(wb_dat_i[2:0]);
    end
  end

  // Clock source and stop-mode behaviour
  assign enabled_w  = (ctrl_q.rate != `WDR_RATE_OFF);
  assign src_tick_w = ctrl_q.sel_high ? edge_w[0] :
                      (ctrl_q.sel_low ? edge_w[2] : edge_w[1]);
  assign stop_run_w = ctrl_q.sel_high ? !ctrl_q.stop_autonomous_clock_disable :
                      (cfg_q.pseudo_stop_enable && cfg_q.pseudo_stop_watchdog_clock_enable && ctrl_q.sel_low &&
                       cfg_q.crystal_oscillator_enable && osc_up_w);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_prev_q <= 1'h0;
    end else begin
      stop_prev_q <= stop_mode_i;
    end
  end

  // Frozen autonomous domain needs some of its own edges to come back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      holdoff_q <= '0;
    end else if (stop_prev_q && !stop_mode_i &&
                 ctrl_q.sel_high && ctrl_q.stop_autonomous_clock_disable) begin
      holdoff_q <= RESUME_CNT;
    end else if ((holdoff_q != '0) && edge_w[0]) begin
      holdoff_q <= holdoff_q - `WDR_HOLD_W'(1);
    end
  end

  assign run_w = enabled_w && src_tick_w && (holdoff_q == '0) &&
                 (!stop_mode_i || stop_run_w);
  // Key sequence and service checks
  assign bad_key_w  = svc_wr_w && !key_ok(key_q, key_w);
  assign early_w    = svc_wr_w && enabled_w && ctrl_q.window &&
                      !in_win_w;
  assign serviced_w = svc_wr_w && enabled_w && !early_w &&
                      (key_q == wdr_pkg::WDR_KEY_ARMED) &&
                      (key_w == `WDR_KEY_SECOND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= wdr_pkg::WDR_KEY_IDLE;
    end else begin
      unique case (key_q)
        wdr_pkg::WDR_KEY_IDLE: begin
          if (svc_wr_w && (key_w == `WDR_KEY_FIRST)) begin
            key_q <= wdr_pkg::WDR_KEY_ARMED;
          end
        end
        wdr_pkg::WDR_KEY_ARMED: begin
          if (svc_wr_w) begin
            key_q <= wdr_pkg::WDR_KEY_IDLE;
          end
        end
        default: key_q <= wdr_pkg::WDR_KEY_IDLE;
      endcase
    end
  end

  // Held until the system reset comes back through rst_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_q <= 1'h0;
    end else if ((expire_w && enabled_w) || bad_key_w || early_w) begin
      reset_q <= 1'h1;
    end
  end

  assign wdt_reset_o = reset_q;
  assign exp_w       = rate_exp(ctrl_q.rate);
  wdr_cnt #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (serviced_w || !enabled_w),
    .tick_i   (run_w),
    .exp_i    (exp_w),
    .count_o  (count_w),
    .expire_o (expire_w),
    .window_o (in_win_w)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_TIMEOUT_RESET: assert property (
    expire_w && enabled_w |=> wdt_reset_o ##1 wdt_reset_o)
    else $error("time-out did not raise reset");
  AST_BAD_KEY: assert property (
    svc_wr_w && (key_w != `WDR_KEY_FIRST) &&
    (key_w != `WDR_KEY_SECOND) |=> wdt_reset_o)
    else $error("foreign service byte did not reset");
  AST_KEY_ORDER: assert property (
    svc_wr_w && (key_q == wdr_pkg::WDR_KEY_IDLE) &&
    (key_w == `WDR_KEY_SECOND) |=> wdt_reset_o)
    else $error("second key without first did not reset");
  AST_EARLY_SERVICE: assert property (
    svc_wr_w && enabled_w && ctrl_q.window && !in_win_w
    |=> wdt_reset_o)
    else $error("premature windowed service did not reset");
  AST_SERVICE_RESTART: assert property (
    serviced_w |=> (count_w == '0) && !wdt_reset_o)
    else $error("valid service did not restart the period");
  AST_OFF_CLEAR: assert property (
    !enabled_w |=> (count_w == '0))
    else $error("counter moved while watchdog off");
  AST_STOP_FREEZE: assert property (
    stop_mode_i && !stop_run_w && enabled_w && !svc_wr_w
    |=> count_w == $past(count_w))
    else $error("counter moved while frozen in stop");
  AST_ACLK_STOP_RUN: assert property (
    stop_mode_i && ctrl_q.sel_high && !ctrl_q.stop_autonomous_clock_disable && enabled_w &&
    edge_w[0] && (holdoff_q == '0) && !svc_wr_w
    |=> count_w != $past(count_w))
    else $error("autonomous clock did not run in stop");
  AST_HOLDOFF: assert property (
    holdoff_q != '0 |-> !run_w)
    else $error("counter resumed before sync latency");
  AST_LOCKED: assert property (
    locked_w && ctrl_wr_w |=> $stable(ctrl_q))
    else $error("locked control register changed");
  AST_MASKED: assert property (
    ctrl_wr_w && mask_w |=> $stable(ctrl_q.rate) &&
    $stable(ctrl_q.window) && (once_q == $past(once_q)))
    else $error("masked write changed the setting");
  AST_ONCE: assert property (
    ctrl_wr_w && normal_mode_i && !mask_w |=> once_q)
    else $error("unmasked write did not use the update");
  AST_NO_OFF: assert property (
    preload_on_q && !first_q |-> enabled_w)
    else $error("preloaded watchdog was turned off");
  AST_PRELOAD: assert property (
    first_q && normal_mode_i && nvm_valid_i
    |=> (ctrl_q.rate == $past(nvm_rate_i)) &&
        (ctrl_q.window == $past(nvm_window_i)))
    else $error("preload not taken at release");
  AST_RELEASE_STATE: assert property (
    first_q |-> !ctrl_q.sel_high && !ctrl_q.sel_low &&
    (ctrl_q.rate == `WDR_RATE_OFF) && !ctrl_q.window)
    else $error("wrong control state at release");
  COV_SERVICE: cover property (serviced_w);
  COV_TIMEOUT: cover property (expire_w && enabled_w);
  COV_EARLY:   cover property (early_w);
  COV_PRELOAD: cover property (first_q && normal_mode_i && nvm_valid_i);

endmodule

// ==== sim/tb_wdr_top.sv ====
/*
  Self-checking bench of the windowed watchdog: Wishbone register access,
  key service, window, write-once, preload and stop-mode clock cases.
  Assumes wdr_top, wdr_pkg and wdr_defs.svh are compiled before it.
*/
`timescale 1ns/1ps
`include "wdr_defs.svh"

module tb_wdr_top;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        wb_ack_o, wdt_reset_o;
  logic [31:0] wb_dat_o;
  logic        aclk_i = 1'b0, irc_clk_i = 1'b0, osc_clk_i = 1'b0;
  logic        osc_up_i = 1'b0, stop_mode_i = 1'b0, normal_mode_i = 1'b0;
  logic        nvm_valid_i = 1'b0, nvm_window_i = 1'b0;
  logic [2:0]  nvm_rate_i = 3'h0;
  logic [3:0]  div_q = 4'h0, osc_q = 4'h0;
  int          miscompares = 0, compares = 0;
  int          n;

  // EXP_BASE 2 gives periods of 4^rate ticks to keep the run short
  wdr_top #(.CNT_W(27), .EXP_BASE(2), .RESUME_TICKS(2)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .aclk_i(aclk_i), .irc_clk_i(irc_clk_i), .osc_clk_i(osc_clk_i),
    .osc_up_i(osc_up_i), .stop_mode_i(stop_mode_i),
    .normal_mode_i(normal_mode_i), .nvm_valid_i(nvm_valid_i),
    .nvm_rate_i(nvm_rate_i), .nvm_window_i(nvm_window_i),
    .wdt_reset_o(wdt_reset_o));

  always #25 clk_i = ~clk_i;

  // Slow sources: irc 8, osc 12 and aclk 16 system clocks per tick
  always @(posedge clk_i) begin
    div_q     <= div_q + 4'h1;
    osc_q     <= (osc_q == 4'hB) ? 4'h0 : osc_q + 4'h1;
    irc_clk_i <= div_q[2];
    aclk_i    <= div_q[3];
    osc_clk_i <= (osc_q < 4'h6);
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask

  // Bounded wait for the watchdog reset; n returns the cycles waited
  task automatic wait_rst(input int lim);
    n = 0;
    while (wdt_reset_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic do_reset(input logic v, input logic [2:0] r,
                          input logic w, input logic nm);
    @(posedge clk_i);
    rst_i         <= 1'b1;
    nvm_valid_i   <= v;
    nvm_rate_i    <= r;
    nvm_window_i  <= w;
    normal_mode_i <= nm;
    stop_mode_i   <= 1'b0;
    @(posedge clk_i);
    rst_i <= 1'b0;
    // Edge after release is the preload edge, no request before it
    @(posedge clk_i);
  endtask

  task automatic t_reset_values();
    do_reset(1'b0, 3'h5, 1'b1, 1'b1);
    rdchk("ctrl", `WDR_OFF_CTRL, 32'h0000_0000);
    rdchk("stat", `WDR_OFF_STAT, 32'h0000_0000);
    rdchk("cfg", `WDR_OFF_CFG, 32'h0000_0000);
    rdchk("unmapped", 8'h10, 32'h0000_0000);
    wait_rst(300);
    check("off_no_reset", n, 300);
  endtask

  task automatic t_periods();
    int e;
    for (int r = 1; r <= 3; r++) begin
      do_reset(1'b0, 3'h0, 1'b0, 1'b0);
      wr(`WDR_OFF_CTRL, 32'(r));
      e = 8 << (2 * r);
      wait_rst(800);
      check("period_min", 32'(n > e - 24), 32'h1);
      check("period_max", 32'(n < e + 24), 32'h1);
    end
  endtask

  task automatic t_service_once();
    do_reset(1'b0, 3'h0, 1'b0, 1'b1);
    wr(`WDR_OFF_CTRL, 32'h0000_0002);
    repeat (4) begin
      repeat (60) @(posedge clk_i);
      wr(`WDR_OFF_SVC, 32'h0000_0055);
      rdchk("armed", `WDR_OFF_SVC, 32'h0000_0001);
      wr(`WDR_OFF_SVC, 32'h0000_00AA);
    end
    check("serviced", wdt_reset_o, 32'h0);
    wr(`WDR_OFF_CTRL, 32'h0000_0021);
    rdchk("once_locked", `WDR_OFF_CTRL, 32'h0000_0002);
    rdchk("once_used", `WDR_OFF_STAT, 32'h0000_0005);
  endtask

  task automatic t_mask();
    do_reset(1'b0, 3'h0, 1'b0, 1'b1);
    wr(`WDR_OFF_CTRL, 32'h0000_0123);
    rdchk("mask_ctrl", `WDR_OFF_CTRL, 32'h0000_0020);
    rdchk("mask_stat", `WDR_OFF_STAT, 32'h0000_0000);
    wr(`WDR_OFF_CTRL, 32'h0000_0023);
    rdchk("after_mask", `WDR_OFF_CTRL, 32'h0000_0023);
  endtask

  task automatic t_preload();
    do_reset(1'b1, 3'h2, 1'b1, 1'b1);
    rdchk("preload", `WDR_OFF_CTRL, 32'h0000_0082);
    wr(`WDR_OFF_CTRL, 32'h0000_0000);
    rdchk("no_off", `WDR_OFF_CTRL, 32'h0000_0002);
  endtask

  task automatic t_bad_keys(input logic [7:0] a, input logic [7:0] b);
    do_reset(1'b0, 3'h0, 1'b0, 1'b0);
    wr(`WDR_OFF_CTRL, 32'h0000_0003);
    wr(`WDR_OFF_SVC, {24'h0, a});
    if (a == `WDR_KEY_FIRST) wr(`WDR_OFF_SVC, {24'h0, b});
    wait_rst(2);
    check("bad_key", wdt_reset_o, 32'h1);
  endtask

  task automatic t_window();
    logic [31:0] q;
    do_reset(1'b0, 3'h0, 1'b0, 1'b0);
    wr(`WDR_OFF_CTRL, 32'h0000_0082);
    wr(`WDR_OFF_SVC, 32'h0000_0055);
    wait_rst(2);
    check("early_svc", wdt_reset_o, 32'h1);
    do_reset(1'b0, 3'h0, 1'b0, 1'b0);
    wr(`WDR_OFF_CTRL, 32'h0000_0082);
    n = 0;
    q = 32'h0;
    while (q[3] !== 1'b1 && n < 100) begin
      bus(1'b0, `WDR_OFF_STAT, 32'h0, q);
      check("no_reset_yet", wdt_reset_o, 32'h0);
      n++;
    end
    check("window_seen", q[3], 32'h1);
    wr(`WDR_OFF_SVC, 32'h0000_0055);
    wr(`WDR_OFF_SVC, 32'h0000_00AA);
    rdchk("late_svc", `WDR_OFF_STAT, 32'h0000_0004);
  endtask

  task automatic stop_case(input logic [7:0] c, input logic [2:0] g,
                           input logic run);
    do_reset(1'b0, 3'h0, 1'b0, 1'b0);
    osc_up_i <= 1'b1;
    wr(`WDR_OFF_CFG, {29'h0, g});
    wr(`WDR_OFF_CTRL, {24'h0, c});
    stop_mode_i <= 1'b1;
    wait_rst(300);
    check("stop_run", 32'(n < 300), 32'(run));
    if (!run) begin
      rdchk("frozen", `WDR_OFF_STAT, 32'h0000_0014);
      stop_mode_i <= 1'b0;
      wait_rst(300);
      check("resumed", wdt_reset_o, 32'h1);
    end
  endtask

  initial begin
    t_reset_values();
    t_periods();
    t_service_once();
    t_mask();
    t_preload();
    t_bad_keys(8'h12, 8'h00);
    t_bad_keys(`WDR_KEY_SECOND, 8'h00);
    t_bad_keys(`WDR_KEY_FIRST, `WDR_KEY_FIRST);
    t_window();
    stop_case(8'h21, 3'h0, 1'b1);
    stop_case(8'h61, 3'h0, 1'b0);
    stop_case(8'h11, 3'h7, 1'b1);
    stop_case(8'h11, 3'h5, 1'b0);
    stop_case(8'h01, 3'h7, 1'b0);
    print_verdict();
  end
endmodule
